//--- hw/mdso_decim.sv
/*
 One-axis acceleration decimator: averages 2^shift consecutive samples
 and emits the mean as a one-cycle pulse with data.
 Assumes samples arrive as one-cycle strobes on core_clk.
*/
`timescale 1ns/1ps
`include "mdso_params.svh"

module mdso_decim
   import mdso_pkg::*;
#(
   parameter int ACC_W = `MDSO_ACC_W,
   parameter int SEL_W = `MDSO_SEL_W
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [SEL_W-1:0] shift,
   input wire logic smp_valid,
   input wire logic [ACC_W-1:0] smp_in,
   output logic avg_valid,
   output logic [ACC_W-1:0] avg_out
);

   // Sum must hold up to 2^(2^SEL_W - 1) samples
   localparam int SUM_W = ACC_W + (1 << SEL_W);
   localparam int CNT_W = 1 << SEL_W;

   logic signed [SUM_W-1:0] sum_r, sum_nxt, sum_add;
   logic [(1 << SEL_W)-1:0] cnt_r, cnt_nxt;
   logic [SEL_W-1:0] shift_r, shift_nxt;
   logic avg_valid_r, avg_valid_nxt;
   logic [ACC_W-1:0] avg_r, avg_nxt;
   logic [(1 << SEL_W)-1:0] last_cnt;

   assign avg_valid = avg_valid_r;
   assign avg_out = avg_r;

   // ****************************************
   // Accumulate and divide by shifting
   // ****************************************
   // A change of ratio restarts the window so no mean mixes two ratios
   always_comb begin
      last_cnt = CNT_W'((32'd1 << shift) - 32'd1); // Window of 2^shift samples
      sum_add = sum_r + SUM_W'(signed'(smp_in));
      sum_nxt = sum_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift;
      avg_valid_nxt = 1'b0;
      avg_nxt = avg_r;
      if (shift != shift_r) begin
         sum_nxt = '0;
         cnt_nxt = '0;
      end else if (smp_valid) begin
         if (cnt_r == last_cnt) begin
            avg_valid_nxt = 1'b1;
            avg_nxt = ACC_W'(sum_add >>> shift);
            sum_nxt = '0;
            cnt_nxt = '0;
         end else begin
            sum_nxt = sum_add;
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sum_r <= '0;
         cnt_r <= '0;
         shift_r <= '0;
         avg_valid_r <= 1'b0;
         avg_r <= '0;
      end else begin
         sum_r <= sum_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         avg_valid_r <= avg_valid_nxt;
         avg_r <= avg_nxt;
      end
   end

endmodule

//--- hw/mdso_params.svh
/*
 Constants of the magnetic status and output register group:
 register addresses, status bit positions, reset values, widths.
 Assumes it is included by bare name from the package and the modules.
*/
`ifndef MDSO_PARAMS_SVH
`define MDSO_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define MDSO_ADDR_STATUS 8'h32
`define MDSO_ADDR_MAG_X_HI 8'h33
`define MDSO_ADDR_MAG_X_LO 8'h34
`define MDSO_ADDR_MAG_Y_HI 8'h35
`define MDSO_ADDR_MAG_Y_LO 8'h36
`define MDSO_ADDR_MAG_Z_HI 8'h37
`define MDSO_ADDR_MAG_Z_LO 8'h38
`define MDSO_ADDR_ACC_X_HI 8'h39
`define MDSO_ADDR_ACC_X_LO 8'h3A
`define MDSO_ADDR_ACC_Y_HI 8'h3B
`define MDSO_ADDR_ACC_Y_LO 8'h3C
`define MDSO_ADDR_ACC_Z_HI 8'h3D
`define MDSO_ADDR_ACC_Z_LO 8'h3E

// ****************************************
// Status bit positions (axis bits add the axis index)
// ****************************************
`define MDSO_ST_XDR 0
`define MDSO_ST_XYZDR 3
`define MDSO_ST_XOW 4
`define MDSO_ST_XYZOW 7

// ****************************************
// Widths and reset values
// ****************************************
`define MDSO_MAG_W 16
`define MDSO_ACC_W 14
`define MDSO_SEL_W 3
`define MDSO_AXES 3
`define MDSO_STATUS_RST 8'h00
`define MDSO_BYTE_ZERO 8'h00
`define MDSO_ALL_READ 3'h7

`endif

//--- hw/mdso_pkg.sv
/*
 Shared types of the magnetic status and output register group.
 Assumes mdso_params.svh is on the include path.
*/
`include "mdso_params.svh"

package mdso_pkg;

   // ****************************************
   // Data types
   // ****************************************
   typedef logic [7:0] mdso_byte_t;
   typedef logic [`MDSO_MAG_W-1:0] mdso_mag_t;
   typedef logic [`MDSO_ACC_W-1:0] mdso_acc_t;
   typedef logic [`MDSO_SEL_W-1:0] mdso_sel_t;
   typedef logic [`MDSO_AXES-1:0] mdso_axes_t;

endpackage

//--- hw/mdso_regs.sv
/*
 Magnetic data-ready/overrun status register, magnetic output
 registers and time-aligned decimated acceleration registers,
 read over a byte read port.
 Assumes acquisitions arrive as one-cycle strobes with their data
 and that read strobes come from the serial interface logic.
*/
`timescale 1ns/1ps
`include "mdso_params.svh"

module mdso_regs
   import mdso_pkg::*;
#(
   parameter int MAG_W = `MDSO_MAG_W,
   parameter int ACC_W = `MDSO_ACC_W,
   parameter int SEL_W = `MDSO_SEL_W
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic mag_x_done,
   input wire logic [MAG_W-1:0] mag_x_sample,
   input wire logic mag_y_done,
   input wire logic [MAG_W-1:0] mag_y_sample,
   input wire logic mag_z_done,
   input wire logic [MAG_W-1:0] mag_z_sample,
   input wire logic accel_valid,
   input wire logic [ACC_W-1:0] accel_x_sample,
   input wire logic [ACC_W-1:0] accel_y_sample,
   input wire logic [ACC_W-1:0] accel_z_sample,
   input wire logic [SEL_W-1:0] output_rate_select,
   input wire logic [SEL_W-1:0] mag_oversample_select,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   output logic rd_valid
);

   // ****************************************
   // Per-axis views of the ports
   // ****************************************
   logic [`MDSO_AXES-1:0] mag_done;
   logic [MAG_W-1:0] mag_in [`MDSO_AXES];
   logic [ACC_W-1:0] acc_in [`MDSO_AXES];

   assign mag_done = {mag_z_done, mag_y_done, mag_x_done};
   assign mag_in[0] = mag_x_sample;
   assign mag_in[1] = mag_y_sample;
   assign mag_in[2] = mag_z_sample;
   assign acc_in[0] = accel_x_sample;
   assign acc_in[1] = accel_y_sample;
   assign acc_in[2] = accel_z_sample;

   // ****************************************
   // Read strobes of the magnetic high bytes
   // ****************************************
   logic [`MDSO_AXES-1:0] hi_rd;

   always_comb begin
      hi_rd = '0;
      if (rd_en) begin
         hi_rd[0] = (rd_addr == `MDSO_ADDR_MAG_X_HI);
         hi_rd[1] = (rd_addr == `MDSO_ADDR_MAG_Y_HI);
         hi_rd[2] = (rd_addr == `MDSO_ADDR_MAG_Z_HI);
      end
   end

   // ****************************************
   // Decimation ratio
   // ****************************************
   // Faster output rates leave fewer samples per period, so the
   // rate select caps the oversample select
   logic [SEL_W-1:0] eff_shift;

   always_comb begin
      if (mag_oversample_select < output_rate_select) begin
         eff_shift = mag_oversample_select;
      end else begin
         eff_shift = output_rate_select;
      end
   end

   // ****************************************
   // Per-axis state: data, ready and overrun flags
   // ****************************************
   logic [MAG_W-1:0] mag_r [`MDSO_AXES];
   logic [MAG_W-1:0] mag_nxt [`MDSO_AXES];
   logic [`MDSO_AXES-1:0] dr_r, dr_nxt;
   logic [`MDSO_AXES-1:0] ow_r, ow_nxt;
   logic [`MDSO_AXES-1:0] avg_valid;
   logic [ACC_W-1:0] avg_out [`MDSO_AXES];
   logic [ACC_W-1:0] dec_r [`MDSO_AXES];
   logic [ACC_W-1:0] dec_nxt [`MDSO_AXES];
   logic [ACC_W-1:0] cmp_r [`MDSO_AXES];
   logic [ACC_W-1:0] cmp_nxt [`MDSO_AXES];
   logic set_evt;

   genvar a;
   generate
      for (a = 0; a < `MDSO_AXES; a++) begin : g_axis
         // Same ratio on every axis keeps the combined set consistent
         mdso_decim #(
            .ACC_W(ACC_W),
            .SEL_W(SEL_W)
         ) u_decim (
            .core_clk(core_clk),
            .nrst(nrst),
            .shift(eff_shift),
            .smp_valid(accel_valid),
            .smp_in(acc_in[a]),
            .avg_valid(avg_valid[a]),
            .avg_out(avg_out[a])
         );

         // Next values of one axis; a new sample wins over a read
         always_comb begin
            mag_nxt[a] = mag_r[a];
            dr_nxt[a] = dr_r[a] & ~hi_rd[a];
            ow_nxt[a] = ow_r[a] & ~hi_rd[a];
            if (mag_done[a]) begin
               mag_nxt[a] = mag_in[a];
               dr_nxt[a] = 1'b1;
               if (dr_r[a]) begin
                  ow_nxt[a] = 1'b1;
               end
            end
         end

         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               mag_r[a] <= '0;
               dr_r[a] <= 1'b0;
               ow_r[a] <= 1'b0;
            end else begin
               mag_r[a] <= mag_nxt[a];
               dr_r[a] <= dr_nxt[a];
               ow_r[a] <= ow_nxt[a];
            end
         end

         // Latest mean, copied out when a full set lands so the host
         // reads acceleration of the same moment as the field
         always_comb begin
            dec_nxt[a] = avg_valid[a] ? avg_out[a] : dec_r[a];
            cmp_nxt[a] = set_evt ? dec_r[a] : cmp_r[a];
         end

         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               dec_r[a] <= '0;
               cmp_r[a] <= '0;
            end else begin
               dec_r[a] <= dec_nxt[a];
               cmp_r[a] <= cmp_nxt[a];
            end
         end
      end
   endgenerate

   // ****************************************
   // All-axes ready and overrun flags
   // ****************************************
   // A set is complete when the last axis of it turns fresh
   logic xyz_dr_r, xyz_dr_nxt;
   logic xyz_ow_r, xyz_ow_nxt;
   mdso_axes_t seen_r, seen_nxt;
   logic all_read;
   logic set_replaced;

   assign set_evt = (&dr_nxt) & ~(&dr_r) & (|mag_done);
   // All three high bytes read since the latest set retire it
   assign all_read = ((seen_r | hi_rd) == `MDSO_ALL_READ);
   // Replacing unread data of an unretired set is an overrun
   assign set_replaced = xyz_dr_r & (|(mag_done & dr_r));

   // Read tracking restarts with every new set and every retirement
   always_comb begin
      seen_nxt = seen_r | hi_rd;
      if (set_evt || all_read) begin
         seen_nxt = '0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         seen_r <= '0;
      end else begin
         seen_r <= seen_nxt;
      end
   end

   // Ready flag; a new set wins over a retirement in the same cycle
   always_comb begin
      xyz_dr_nxt = xyz_dr_r;
      if (set_evt) begin
         xyz_dr_nxt = 1'b1;
      end else if (all_read) begin
         xyz_dr_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         xyz_dr_r <= 1'b0;
      end else begin
         xyz_dr_r <= xyz_dr_nxt;
      end
   end

   // Overrun flag; an overwrite wins over a retirement in the same cycle
   always_comb begin
      xyz_ow_nxt = xyz_ow_r;
      if (set_replaced) begin
         xyz_ow_nxt = 1'b1;
      end else if (all_read) begin
         xyz_ow_nxt = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         xyz_ow_r <= 1'b0;
      end else begin
         xyz_ow_r <= xyz_ow_nxt;
      end
   end

   // ****************************************
   // Status byte assembly
   // ****************************************
   mdso_byte_t status;

   always_comb begin
      status = `MDSO_STATUS_RST;
      for (int i = 0; i < `MDSO_AXES; i++) begin
         status[`MDSO_ST_XDR + i] = dr_r[i];
         status[`MDSO_ST_XOW + i] = ow_r[i];
      end
      status[`MDSO_ST_XYZDR] = xyz_dr_r;
      status[`MDSO_ST_XYZOW] = xyz_ow_r;
   end

   // ****************************************
   // Read data mux
   // ****************************************
   // Aligned acceleration is right-justified; the high byte carries
   // the sign extension above bit 13
   logic [MAG_W-1:0] cmp_ext [`MDSO_AXES];
   mdso_byte_t rd_data_r, rd_data_nxt;
   logic rd_valid_r, rd_valid_nxt;

   always_comb begin
      for (int i = 0; i < `MDSO_AXES; i++) begin
         cmp_ext[i] = MAG_W'(signed'(cmp_r[i]));
      end
   end

   always_comb begin
      rd_data_nxt = `MDSO_BYTE_ZERO;
      if (rd_en) begin
         unique case (rd_addr)
            `MDSO_ADDR_STATUS: rd_data_nxt = status;
            `MDSO_ADDR_MAG_X_HI: rd_data_nxt = mag_r[0][15:8];
            `MDSO_ADDR_MAG_X_LO: rd_data_nxt = mag_r[0][7:0];
            `MDSO_ADDR_MAG_Y_HI: rd_data_nxt = mag_r[1][15:8];
            `MDSO_ADDR_MAG_Y_LO: rd_data_nxt = mag_r[1][7:0];
            `MDSO_ADDR_MAG_Z_HI: rd_data_nxt = mag_r[2][15:8];
            `MDSO_ADDR_MAG_Z_LO: rd_data_nxt = mag_r[2][7:0];
            `MDSO_ADDR_ACC_X_HI: rd_data_nxt = cmp_ext[0][15:8];
            `MDSO_ADDR_ACC_X_LO: rd_data_nxt = cmp_ext[0][7:0];
            `MDSO_ADDR_ACC_Y_HI: rd_data_nxt = cmp_ext[1][15:8];
            `MDSO_ADDR_ACC_Y_LO: rd_data_nxt = cmp_ext[1][7:0];
            `MDSO_ADDR_ACC_Z_HI: rd_data_nxt = cmp_ext[2][15:8];
            `MDSO_ADDR_ACC_Z_LO: rd_data_nxt = cmp_ext[2][7:0];
            default: rd_data_nxt = `MDSO_BYTE_ZERO; // Unmapped reads zero
         endcase
      end
   end

   // Read data registered so the outputs come straight from flops
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data_r <= `MDSO_BYTE_ZERO;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   // Every read is answered exactly one cycle after its strobe
   always_comb begin
      rd_valid_nxt = rd_en;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= rd_valid_nxt;
      end
   end

   assign rd_data = rd_data_r;
   assign rd_valid = rd_valid_r;

endmodule

//--- tb/mdso_host.sv
/*
 Host model: issues single byte reads on the register read port.
 Assumes one read at a time and that the answer comes one cycle later.
*/
`timescale 1ns/1ps

module mdso_host (
   input wire logic core_clk,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   // Idle bus at time zero
   initial begin
      rd_en = 1'b0;
      rd_addr = 8'h00;
   end

   // Address is scrambled after use so stale values never look valid
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      @(posedge core_clk);
      d = (rd_valid === 1'b1) ? rd_data : ~rd_data; // Missing answer shows as mismatch
   endtask
endmodule

//--- tb/mdso_regs_monitor.sv
/*
 Concurrent checks on the read port and status of the register group.
 Assumes it is bound to every mdso_regs instance and sees its ports only.
*/
`timescale 1ns/1ps

module mdso_regs_monitor
   import mdso_pkg::*;
#(
   parameter int MAG_W = 16
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic mag_x_done,
   input wire logic [MAG_W-1:0] mag_x_sample,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ****************************************
   // Assertions
   // ****************************************
   // Reads of one axis are spaced by the idle cycles the host leaves
   a_read_latency: assert property (rd_en |=> rd_valid)
      else $error("read not answered after one cycle");
   a_no_spurious: assert property (!rd_en |=> !rd_valid && rd_data == 8'h00)
      else $error("answer without a read");
   a_mag_x_high: assert property (
      mag_x_done ##1 (!rd_en && !mag_x_done) ##1
      (rd_en && rd_addr == 8'h33 && !mag_x_done) |=> rd_data == $past(mag_x_sample[15:8], 3))
      else $error("x high byte differs from last sample");
   a_status_xdr: assert property (
      mag_x_done ##1 !rd_en ##1
      (rd_en && rd_addr == 8'h32 && !mag_x_done) |=> rd_data[0])
      else $error("x ready missing after acquisition");
   a_xow_set: assert property (
      mag_x_done ##1 !rd_en ##1 mag_x_done ##1 !rd_en ##1
      (rd_en && rd_addr == 8'h32 && !mag_x_done) |=> rd_data[4] && rd_data[0])
      else $error("x overrun missing after overwrite");
   a_axis_clear: assert property (
      (rd_en && rd_addr == 8'h33 && !mag_x_done) ##1
      (!rd_en && !mag_x_done) [*2] ##1 (rd_en && rd_addr == 8'h32 && !mag_x_done)
      |=> !rd_data[0] && !rd_data[4])
      else $error("x flags not cleared by high byte read");
   a_accel_sign: assert property (
      rd_en && rd_addr inside {8'h39, 8'h3B, 8'h3D}
      |=> rd_data[7:6] == {2{rd_data[5]}})
      else $error("aligned high byte not sign extended");
   a_unmapped_zero: assert property (
      rd_en && !(rd_addr inside {[8'h32:8'h3E]})
      |=> rd_data == 8'h00)
      else $error("unmapped address not zero");

   // ****************************************
   // Coverage of the main scenarios
   // ****************************************
   c_overwrite: cover property (mag_x_done ##2 mag_x_done);
   c_status_read: cover property (rd_en && rd_addr == 8'h32);
   c_overrun_seen: cover property (rd_valid && rd_data[7]);
endmodule

bind mdso_regs mdso_regs_monitor #(.MAG_W(MAG_W)) mdso_regs_monitor_inst (.core_clk,
   .nrst, .mag_x_done, .mag_x_sample, .rd_en, .rd_addr, .rd_data, .rd_valid);

//--- tb/testbench.sv
/*
 Self-checking bench of the magnetic status and output registers.
 Assumes the host model on the read port and the bound monitor.
*/
`timescale 1ns/1ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
   $display("ERROR %0t: got %h exp %h", $time, a, e); end end

module testbench;
   import mdso_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] done = 3'h0;
   mdso_mag_t mx = 16'h0000, my = 16'h0000, mz = 16'h0000;
   logic accel_valid = 1'b0;
   mdso_acc_t ax = 14'h0000, ay = 14'h0000, az = 14'h0000;
   mdso_sel_t rate_sel = 3'h0, os_sel = 3'h0;
   logic rd_en, rd_valid;
   logic [7:0] rd_addr, rd_data;
   int fails = 0;
   int checked = 0;

   // ****************************************
   // Clock, design and host
   // ****************************************
   always #25 core_clk = ~core_clk;

   mdso_regs mdso_regs_inst (.core_clk(core_clk), .nrst(nrst), .mag_x_done(done[0]),
      .mag_x_sample(mx), .mag_y_done(done[1]), .mag_y_sample(my), .mag_z_done(done[2]),
      .mag_z_sample(mz), .accel_valid(accel_valid), .accel_x_sample(ax),
      .accel_y_sample(ay), .accel_z_sample(az), .output_rate_select(rate_sel),
      .mag_oversample_select(os_sel), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid));

   mdso_host mdso_host_inst (.core_clk(core_clk), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .rd_valid(rd_valid));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      mdso_host_inst.read_byte(a, d);
      `CHK(d, e)
   endtask

   // One-cycle acquisition strobes on the axes in the mask
   task automatic acq(input logic [2:0] m, input mdso_mag_t x, y, z);
      @(posedge core_clk);
      done <= m;
      mx <= x;
      my <= y;
      mz <= z;
      @(posedge core_clk);
      done <= 3'h0;
   endtask

   task automatic acc(input mdso_acc_t x, y, z);
      @(posedge core_clk);
      accel_valid <= 1'b1;
      ax <= x;
      ay <= y;
      az <= z;
      @(posedge core_clk);
      accel_valid <= 1'b0;
   endtask

   task automatic finish_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      rd(8'h32, 8'h00);
      rd(8'h31, 8'h00);
      rd(8'h40, 8'h00);
      // Single-sample mean, then a full set latches it
      acc(14'h3ABC, 14'h0123, 14'h1FFF);
      acq(3'h7, 16'h8123, 16'h7F01, 16'h00FF);
      rd(8'h32, 8'h0F);
      rd(8'h33, 8'h81);
      rd(8'h32, 8'h0E);
      rd(8'h34, 8'h23);
      rd(8'h35, 8'h7F);
      rd(8'h36, 8'h01);
      rd(8'h37, 8'h00);
      rd(8'h38, 8'hFF);
      rd(8'h32, 8'h00);
      rd(8'h39, 8'hFA);
      rd(8'h3A, 8'hBC);
      rd(8'h3B, 8'h01);
      rd(8'h3C, 8'h23);
      rd(8'h3D, 8'h1F);
      rd(8'h3E, 8'hFF);
      // Overwrite of unread x while the full set is pending
      acq(3'h7, 16'h1111, 16'h2222, 16'h3333);
      acq(3'h1, 16'h4444, 16'h2222, 16'h3333);
      rd(8'h32, 8'h9F);
      rd(8'h33, 8'h44);
      rd(8'h35, 8'h22);
      rd(8'h32, 8'h8C);
      rd(8'h37, 8'h33);
      rd(8'h32, 8'h00);
      // Two-sample window: the smaller of the two selects wins
      rate_sel <= 3'h1;
      os_sel <= 3'h2;
      repeat (2) @(posedge core_clk);
      acc(14'h0010, 14'h0030, 14'h3FFE);
      acc(14'h0020, 14'h0050, 14'h0000);
      acq(3'h7, 16'h0001, 16'h0002, 16'h0003);
      rd(8'h3A, 8'h18);
      rd(8'h3C, 8'h40);
      rd(8'h3D, 8'hFF);
      rd(8'h3E, 8'hFF);
      rd(8'h33, 8'h00);
      rd(8'h35, 8'h00);
      rd(8'h37, 8'h00);
      // Oversample select below the rate select now sets a one-sample window
      os_sel <= 3'h0;
      repeat (2) @(posedge core_clk);
      acc(14'h2001, 14'h0007, 14'h0100);
      acq(3'h7, 16'h0000, 16'h0000, 16'h0000);
      rd(8'h39, 8'hE0);
      rd(8'h3A, 8'h01);
      rd(8'h3C, 8'h07);
      finish_test();
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      finish_test();
   end
endmodule
